// ---- verilog/ssp_port.v ----
`timescale 1ns/1ps
`include "ssp_consts.vh"
// Function
// [RULE1] Port off in power-down or reset
// [RULE2] Chip select high: ignore inputs, float out
// [RULE3] Chip select rise aborts, no write
// [RULE4] Master keeps delays after abort
// [RULE5] Write: flag 1, address, data
// [RULE6] Read: flag 0 address, device drives data
// [RULE7] Sample rising, shift out falling
// [RULE8] Master spaces writes 50 us
// [RULE9] Master waits 50 us write-to-read
// [RULE10] Master waits 250 ns after read
// [RULE11] Batch read returns seven bytes
// [RULE12] Batch values latched after address
// [RULE13] After burst, chip select must reset
// [RULE14] Master arms download via hidden writes
// [RULE15] Enable 0x18 then burst to port
// [RULE16] Master paces download bytes
// [RULE17] Bytes beyond image ignored
// [RULE18] Grab stores 1536 pixels, stops navigation
// [RULE19] Stream zeros before ready, after end
// [RULE20] Pixel MSB set, bit 6 marks frames
// [RULE21] Long chip select high resets port
// [RULE22] Unmapped write ignored, read zero
// [RULE23] Master waits 75 us for motion
// [RULE24] Master waits 50 us otherwise
// [RULE25] Chip select high 4 us exits burst
// [RULE26] Burst bytes spaced 10 us
module ssp_port #(
    parameter BEXIT_CYC = `SSP_BEXIT_CYC,
    parameter [7:0] ID_CODE = 8'h5A // Arbitrary identity value
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Serial pins from master
    input wire i_sclk,
    input wire i_mosi,
    input wire i_chip_select_n,
    output reg o_miso_out,
    output reg o_miso_oe_n,
    // Device control pins
    input wire i_dev_reset,
    input wire i_power_down_n,
    // Motion results from the core
    input wire [7:0] i_motion,
    input wire [7:0] i_dx,
    input wire [7:0] i_dy,
    input wire [7:0] i_surface_quality,
    input wire [15:0] i_exposure,
    input wire [7:0] i_peak,
    // Pixel source for capture
    input wire i_pix_valid,
    input wire [5:0] i_pix_data,
    input wire i_pix_sof,
    // Firmware image stream out
    output reg o_fw_valid,
    output reg [7:0] o_fw_data,
    input wire i_fw_ready,
    // Status
    output reg o_nav_enable,
    output reg [7:0] o_config,
    output reg o_fw_load_on
);
    localparam ST_ADDR = 3'd0;
    localparam ST_WDATA = 3'd1;
    localparam ST_RDATA = 3'd2;
    localparam ST_FWLOAD = 3'd3;
    localparam ST_BURST_RD = 3'd4;
    localparam ST_LOCKED = 3'd5;

    // Three-stage synchronisers for pins
    reg [2:0] s_sclk, s_mosi, s_cs, s_rst, s_pd;
    always @(posedge i_clk) begin
        s_sclk <= {s_sclk[1:0], i_sclk};
        s_mosi <= {s_mosi[1:0], i_mosi};
        s_cs <= {s_cs[1:0], i_chip_select_n};
        s_rst <= {s_rst[1:0], i_dev_reset};
        s_pd <= {s_pd[1:0], i_power_down_n};
    end

    // Filtered levels: change only when stages 2 and 3 agree
    reg sclk_q, mosi_q, cs_q, drst_q, pd_q;
    always @(posedge i_clk) begin
        if (i_rst) begin
            sclk_q <= 1'b1; // Idle level of the link clock, no false edge
            mosi_q <= 1'b0;
            cs_q <= 1'b1;
            drst_q <= 1'b0;
            pd_q <= 1'b1;
        end else begin
            if (s_sclk[1] == s_sclk[2]) sclk_q <= s_sclk[2];
            if (s_mosi[1] == s_mosi[2]) mosi_q <= s_mosi[2];
            if (s_cs[1] == s_cs[2]) cs_q <= s_cs[2];
            if (s_rst[1] == s_rst[2]) drst_q <= s_rst[2];
            if (s_pd[1] == s_pd[2]) pd_q <= s_pd[2];
        end
    end

    reg sclk_d;
    wire port_on = pd_q && !drst_q; // [RULE1]
    wire active = port_on && !cs_q; // [RULE2]
    wire sclk_rise = active && sclk_q && !sclk_d; // [RULE7]
    wire sclk_fall = active && !sclk_q && sclk_d; // [RULE7]

    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [7:0] shift_in;
    reg [6:0] addr;
    reg [7:0] tx_shift;
    reg [55:0] batch;
    reg [2:0] batch_left;
    reg [10:0] fw_count;
    reg [15:0] cs_high_cnt;
    reg [7:0] fw_en;
    // Capture store
    reg [7:0] grab_mem [0:1535];
    reg [10:0] grab_wr;
    reg [10:0] grab_rd;
    reg grab_busy;
    reg grab_ready;
    reg [7:0] grab_q;
    wire [7:0] byte_in = {shift_in[6:0], mosi_q};
    wire byte_done = sclk_rise && (bit_cnt == 3'd7);
    wire fifo_in_ready;

    // Register read mux; unmapped reads return zero
    // Decodes the address byte as it completes, since addr lands a cycle late
    reg [7:0] rd_val;
    always @* begin
        case (byte_in[6:0])
            `SSP_ADDR_ID: rd_val = ID_CODE;
            `SSP_ADDR_ID_INV: rd_val = ~ID_CODE;
            `SSP_ADDR_MOTION: rd_val = i_motion;
            `SSP_ADDR_DX: rd_val = i_dx;
            `SSP_ADDR_DY: rd_val = i_dy;
            `SSP_ADDR_QUAL: rd_val = i_surface_quality;
            `SSP_ADDR_PEAK: rd_val = i_peak;
            `SSP_ADDR_CONFIG: rd_val = o_config;
            `SSP_ADDR_EXP_LO: rd_val = i_exposure[7:0];
            `SSP_ADDR_EXP_HI: rd_val = i_exposure[15:8];
            `SSP_ADDR_FW_VER: rd_val = {5'h00, fw_count[10:8]};
            default: rd_val = `SSP_RST_ZERO; // [RULE22]
        endcase
    end

    // Capture memory read, registered
    always @(posedge i_clk) begin
        grab_q <= grab_mem[grab_rd];
    end

    // Pixel capture writer; pixel marks added on store
    always @(posedge i_clk) begin
        if (grab_busy && i_pix_valid && (grab_wr != 11'd0 || i_pix_sof)) begin
            grab_mem[grab_wr] <= {1'b1, (grab_wr == 11'd0) || (grab_wr == `SSP_FRAME_BYTES),
                i_pix_data}; // [RULE20]
        end
    end

    // Stream byte: zeros before ready or past end
    wire [7:0] pix_byte = (grab_ready && grab_rd < `SSP_GRAB_BYTES) ? grab_q
        : `SSP_RST_ZERO; // [RULE19]

    // Serial protocol engine
    always @(posedge i_clk) begin
        if (i_rst) begin
            sclk_d <= 1'b1;
            state <= ST_ADDR;
            bit_cnt <= 3'd0;
            shift_in <= 8'h00;
            addr <= 7'h00;
            tx_shift <= 8'h00;
            batch <= 56'h0;
            batch_left <= 3'd0;
            fw_count <= 11'd0;
            cs_high_cnt <= 16'd0;
            fw_en <= `SSP_RST_ZERO;
            o_config <= `SSP_RST_CONFIG;
            o_nav_enable <= 1'b1;
            o_fw_load_on <= 1'b0;
            grab_wr <= 11'd0;
            grab_rd <= 11'd0;
            grab_busy <= 1'b0;
            grab_ready <= 1'b0;
            o_miso_out <= 1'b0;
            o_miso_oe_n <= 1'b1;
        end else begin
            sclk_d <= sclk_q;
            // Device reset pin restores navigation
            if (drst_q) begin
                o_nav_enable <= 1'b1; // [RULE18]
                grab_busy <= 1'b0;
                grab_ready <= 1'b0;
                fw_count <= 11'd0;
                fw_en <= `SSP_RST_ZERO;
            end
            // Capture progress
            if (grab_busy && i_pix_valid && (grab_wr != 11'd0 || i_pix_sof)) begin
                grab_wr <= grab_wr + 11'd1;
                if (grab_wr == `SSP_GRAB_BYTES - 11'd1) begin
                    grab_busy <= 1'b0;
                    grab_ready <= 1'b1;
                end
            end
            // MISO floats unless selected, powered and out of device reset
            o_miso_oe_n <= !active; // [RULE2]
            if (!active) begin
                // Abort: serial state only, control registers kept
                state <= (state == ST_LOCKED || state == ST_FWLOAD
                    || state == ST_BURST_RD) && cs_high_cnt < BEXIT_CYC
                    ? state : ST_ADDR; // [RULE3] [RULE21] [RULE13]
                if (cs_high_cnt < BEXIT_CYC) cs_high_cnt <= cs_high_cnt + 16'd1;
                bit_cnt <= 3'd0;
                o_fw_load_on <= 1'b0;
            end else begin
                cs_high_cnt <= 16'd0;
                if (sclk_rise) begin
                    bit_cnt <= bit_cnt + 3'd1;
                    shift_in <= byte_in;
                end
                if (sclk_fall && (state == ST_RDATA || state == ST_BURST_RD)) begin
                    o_miso_out <= tx_shift[7]; // [RULE7]
                    tx_shift <= {tx_shift[6:0], 1'b0};
                end
                case (state)
                    ST_ADDR: begin
                        if (byte_done) begin
                            addr <= byte_in[6:0];
                            if (byte_in[`SSP_DIR_BIT]) begin
                                state <= ST_WDATA; // [RULE5]
                                if (byte_in[6:0] == `SSP_ADDR_FW_PORT
                                    && fw_en == `SSP_FW_EN_LOAD) begin
                                    state <= ST_FWLOAD; // [RULE15]
                                    o_fw_load_on <= 1'b1;
                                end
                            end else begin
                                state <= ST_RDATA; // [RULE6]
                                tx_shift <= rd_val;
                                case (byte_in[6:0])
                                    `SSP_ADDR_MOT_BURST: begin
                                        batch <= {i_motion, i_dx, i_dy, i_surface_quality,
                                            i_exposure[15:8], i_exposure[7:0], i_peak};
                                        tx_shift <= i_motion; // [RULE12] [RULE11]
                                        batch_left <= `SSP_BATCH_BYTES - 3'd1;
                                        state <= ST_BURST_RD;
                                    end
                                    `SSP_ADDR_PIX_BURST: begin
                                        tx_shift <= pix_byte;
                                        // Early reads must not eat pixels
                                        if (grab_ready) grab_rd <= grab_rd + 11'd1; // [RULE19]
                                        batch_left <= 3'd0;
                                        state <= ST_BURST_RD;
                                    end
                                    default: ;
                                endcase
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            state <= ST_ADDR;
                            case (addr)
                                `SSP_ADDR_CONFIG: o_config <= byte_in;
                                `SSP_ADDR_FW_EN: fw_en <= byte_in;
                                `SSP_ADDR_GRAB: begin
                                    o_nav_enable <= 1'b0; // [RULE18]
                                    fw_count <= 11'd0;
                                    grab_busy <= 1'b1;
                                    grab_ready <= 1'b0;
                                    grab_wr <= 11'd0;
                                    grab_rd <= 11'd0;
                                end
                                default: ; // [RULE22]
                            endcase
                        end
                    end
                    ST_RDATA: begin
                        if (byte_done) state <= ST_ADDR;
                    end
                    ST_FWLOAD: begin
                        // Stall-free: full FIFO drops, master pacing avoids it
                        if (byte_done && fw_count < `SSP_FW_BYTES) begin
                            fw_count <= fw_count + 11'd1; // [RULE17]
                        end
                    end
                    ST_BURST_RD: begin
                        if (byte_done) begin
                            if (addr == `SSP_ADDR_PIX_BURST) begin
                                tx_shift <= pix_byte;
                                if (grab_ready && grab_rd != 11'h7FF) grab_rd <= grab_rd + 11'd1;
                            end else if (batch_left != 3'd0) begin
                                batch_left <= batch_left - 3'd1;
                                tx_shift <= batch[8*batch_left-1 -: 8];
                            end else begin
                                // Last byte shifted out; wait for the chip select exit
                                state <= ST_LOCKED; // [RULE13]
                            end
                        end
                    end
                    ST_LOCKED: ; // [RULE13]
                    default: state <= ST_ADDR;
                endcase
            end
        end
    end

    // Firmware bytes queued toward the loader
    wire fw_push = active && state == ST_FWLOAD && byte_done
        && fw_count < `SSP_FW_BYTES && fifo_in_ready; // [RULE17]
    wire fw_out_valid;
    wire [7:0] fw_out_data;
    ssp_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(fw_push),
        .i_in_data(byte_in),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fw_out_valid),
        .o_out_data(fw_out_data),
        .i_out_ready(i_fw_ready)
    );

    // Registered copy of the FIFO output
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_fw_valid <= 1'b0;
            o_fw_data <= 8'h00;
        end else begin
            o_fw_valid <= fw_out_valid && i_fw_ready;
            o_fw_data <= fw_out_data;
        end
    end
endmodule // ssp_port

// ---- verilog/ssp_consts.vh ----
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
// Command byte layout
`define SSP_DIR_BIT 7
// Register addresses (7-bit)
`define SSP_ADDR_ID 7'h00
`define SSP_ADDR_ID_INV 7'h3F
`define SSP_ADDR_MOTION 7'h02
`define SSP_ADDR_DX 7'h03
`define SSP_ADDR_DY 7'h04
`define SSP_ADDR_QUAL 7'h05
`define SSP_ADDR_PEAK 7'h07
`define SSP_ADDR_CONFIG 7'h0A
`define SSP_ADDR_EXP_LO 7'h0E
`define SSP_ADDR_EXP_HI 7'h0F
`define SSP_ADDR_GRAB 7'h13
`define SSP_ADDR_FW_EN 7'h14
`define SSP_ADDR_FW_VER 7'h1F
`define SSP_ADDR_PIX_BURST 7'h40
`define SSP_ADDR_MOT_BURST 7'h50
`define SSP_ADDR_FW_PORT 7'h60
// Reset values
`define SSP_RST_CONFIG 8'h09
`define SSP_RST_ZERO 8'h00
// Firmware enable value that arms the download
`define SSP_FW_EN_LOAD 8'h18
// Counts
`define SSP_FW_BYTES 11'd1986
`define SSP_GRAB_BYTES 11'd1536
`define SSP_FRAME_BYTES 11'd900
`define SSP_BATCH_BYTES 3'd7
// Pixel marker bits
`define SSP_PIX_VALID_BIT 7
`define SSP_PIX_SOF_BIT 6
// Chip-select high time that leaves burst mode
`define SSP_BEXIT_NS 4000
`define SSP_CLK_NS 8
`define SSP_BEXIT_CYC ((`SSP_BEXIT_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`endif

// ---- verilog/ssp_fifo.v ----
`timescale 1ns/1ps
`include "ssp_consts.vh"
module ssp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output reg o_in_ready,
    // Drain side
    output reg o_out_valid,
    output reg [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // Output register sits outside the count, so pop frees a memory slot as it loads the register
    assign push = i_in_valid && o_in_ready;
    assign pop = (count != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);

    // Pointer and occupancy bookkeeping
    always @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                o_out_data <= mem[rd_ptr];
                rd_ptr <= rd_ptr + 1'b1;
                o_out_valid <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            // Registered ready, one slot of margin for the push in flight
            o_in_ready <= (count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop})
                < DEPTH - 1;
        end
    end
endmodule // ssp_fifo

// ---- testbench/ssp_port_properties.sv ----
`timescale 1ns/1ps
// Pin-level relations of the serial port
module ssp_port_chk #(
    parameter BEXIT_CYC = 500
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Serial and control pins
    input wire i_sclk,
    input wire i_chip_select_n,
    input wire i_dev_reset,
    input wire i_power_down_n,
    input wire o_miso_out,
    input wire o_miso_oe_n,
    // Image stream and status
    input wire o_fw_valid,
    input wire i_fw_ready,
    input wire o_fw_load_on,
    input wire o_nav_enable,
    input wire [7:0] o_config
);
    reg [11:0] fw_taken;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Image bytes handed on since the last clear
    always @(posedge i_clk) begin
        if (i_rst || i_dev_reset)
            fw_taken <= 12'h000;
        else if (o_fw_valid && i_fw_ready)
            fw_taken <= fw_taken + 12'h001;
    end
    a_cs_float: assert property (i_chip_select_n [*8] |-> o_miso_oe_n)
        else $error("MISO driven while deselected");
    a_pd_float: assert property (!i_power_down_n [*8] |-> o_miso_oe_n)
        else $error("MISO driven in power down");
    a_pin_float: assert property (i_dev_reset [*8] |-> o_miso_oe_n)
        else $error("MISO driven during reset pin");
    // Window starts past the select settling, so only shifting can move MISO
    a_miso_hold: assert property (!i_chip_select_n [*8] ##1
        (i_sclk && !i_chip_select_n) [*6] |-> $stable(o_miso_out))
        else $error("MISO moved while clock high");
    a_nav_back: assert property ($fell(i_dev_reset) |-> ##[0:16] o_nav_enable)
        else $error("Navigation not restored by reset pin");
    a_fw_limit: assert property (fw_taken <= 12'h7C2)
        else $error("Image bytes beyond image length");
    a_fw_window: assert property (o_fw_valid |-> o_fw_load_on)
        else $error("Image byte outside download");
    a_cfg_sel: assert property (o_config != $past(o_config) |-> !i_chip_select_n)
        else $error("Config changed while deselected");
endmodule // ssp_port_chk

bind ssp_port ssp_port_chk #(.BEXIT_CYC(BEXIT_CYC)) i_chk (
    .i_clk, .i_rst, .i_sclk, .i_chip_select_n, .i_dev_reset, .i_power_down_n,
    .o_miso_out, .o_miso_oe_n, .o_fw_valid, .i_fw_ready, .o_fw_load_on,
    .o_nav_enable, .o_config
);

// ---- testbench/ssp_host.sv ----
`timescale 1ns/1ps
// Serial master; its clock idles high and stands still between frames
module ssp_host (
    // Pins to device
    output logic o_sclk,
    output logic o_mosi,
    output logic o_cs_n,
    input wire i_miso,
    input wire i_miso_oe_n
);
    logic last = 1'b0;
    logic lvl;
    // Released line shows the inverse, never a stale copy
    assign lvl = i_miso_oe_n ? ~last : i_miso;
    always @(i_miso or i_miso_oe_n)
        if (!i_miso_oe_n)
            last = i_miso;
    initial begin
        o_sclk = 1'b1;
        o_mosi = 1'b1;
        o_cs_n = 1'b1;
    end
    // Drive on falling, take MISO on rising; MSB first
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            o_sclk = 1'b0;
            o_mosi = tx[i];
            #62.5;
            o_sclk = 1'b1;
            rx[i] = lvl;
            #62.5;
        end
    endtask
    task automatic sel();
        o_cs_n = 1'b0;
        #120;
    endtask
    // Gap after the frame covers abort and exit too
    task automatic desel(input int gap);
        #120;
        o_cs_n = 1'b1;
        #gap;
    endtask
    // Two-byte write, then the write spacing
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rx;
        sel();
        shift({1'b1, a}, 8, rx);
        shift(d, 8, rx);
        desel(50000);
    endtask
    // Read with address-to-data wait
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic [7:0] rx;
        sel();
        shift({1'b0, a}, 8, rx);
        #50000;
        shift(8'h00, 8, d);
        desel(250);
    endtask
endmodule // ssp_host

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
// Register access, bursts and download through the host model
module testbench;
    localparam [7:0] ID = 8'h5A; // Arbitrary identity value
    localparam [55:0] MOT = 56'h8012FE4012343F;
    logic clk, rst, sclk, mosi, cs_n, miso, oe_n, dev_rst, pd_n;
    logic fw_valid, fw_ready, fw_on, nav;
    logic [7:0] mot, dx, dy, qual, peak, fw_data, cfg, rd_v;
    logic [15:0] expo;
    logic pix_valid, pix_sof;
    logic [5:0] pix_data;
    logic [7:0] fw_q[$];
    int err_count = 0;
    int num_checks = 0;
    ssp_port #(.BEXIT_CYC(8), .ID_CODE(ID)) i_dut (
        .i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_mosi(mosi),
        .i_chip_select_n(cs_n), .o_miso_out(miso), .o_miso_oe_n(oe_n),
        .i_dev_reset(dev_rst), .i_power_down_n(pd_n), .i_motion(mot), .i_dx(dx),
        .i_dy(dy), .i_surface_quality(qual), .i_exposure(expo), .i_peak(peak),
        .i_pix_valid(pix_valid), .i_pix_data(pix_data), .i_pix_sof(pix_sof),
        .o_fw_valid(fw_valid), .o_fw_data(fw_data), .i_fw_ready(fw_ready),
        .o_nav_enable(nav), .o_config(cfg), .o_fw_load_on(fw_on)
    );
    ssp_host i_host (
        .o_sclk(sclk), .o_mosi(mosi), .o_cs_n(cs_n), .i_miso(miso), .i_miso_oe_n(oe_n)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Image bytes taken by the drain side
    always @(posedge clk)
        if (fw_valid && fw_ready)
            fw_q.push_back(fw_data);
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic at_edge();
        @(posedge clk);
        #1;
    endtask
    initial begin
        #1200000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        dev_rst = 1'b0;
        pd_n = 1'b1;
        fw_ready = 1'b1;
        pix_valid = 1'b0;
        pix_sof = 1'b0;
        pix_data = 6'h00;
        {mot, dx, dy, qual, expo, peak} = 56'h0;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check("oe_n idle", oe_n, 1'b1);
        i_host.wr(7'h0A, 8'h3C);
        check("cfg write", cfg, 8'h3C);
        i_host.rd(7'h0A, rd_v);
        check("cfg read", rd_v, 8'h3C);
        // Abort mid data byte, then the port must answer afresh
        i_host.sel();
        i_host.shift(8'h8A, 8, rd_v);
        i_host.shift(8'h66, 4, rd_v);
        i_host.desel(50000);
        check("cfg after abort", cfg, 8'h3C);
        i_host.rd(7'h00, rd_v);
        check("id after abort", rd_v, ID);
        i_host.rd(7'h30, rd_v);
        check("unmapped read", rd_v, 8'h00);
        // Batch read; inputs change after the address to prove latching
        at_edge();
        {mot, dx, dy, qual, expo, peak} = MOT;
        i_host.sel();
        i_host.shift(8'h50, 8, rd_v);
        #1000;
        at_edge();
        {mot, dx, dy, qual, expo, peak} = 56'h0;
        #74000;
        for (int i = 0; i < 7; i++) begin
            i_host.shift(8'h00, 8, rd_v);
            check("batch byte", rd_v, MOT[55 - 8 * i -: 8]);
        end
        // Write in the same frame must be refused until chip select stays high for the burst exit time
        i_host.shift(8'h8A, 8, rd_v);
        i_host.shift(8'h11, 8, rd_v);
        i_host.desel(50000);
        check("cfg locked", cfg, 8'h3C);
        i_host.wr(7'h13, 8'h00);
        check("nav after grab", nav, 1'b0);
        i_host.rd(7'h40, rd_v);
        check("pixel not ready", rd_v, 8'h00);
        // Feed one capture, first pixel flagged as frame start
        for (int k = 0; k < 1536; k++) begin
            at_edge();
            pix_valid = 1'b1;
            pix_sof = (k == 0);
            pix_data = k[5:0];
        end
        at_edge();
        pix_valid = 1'b0;
        pix_sof = 1'b0;
        i_host.sel();
        i_host.shift(8'h40, 8, rd_v);
        #50000;
        i_host.shift(8'h00, 8, rd_v);
        check("pixel first", rd_v, 8'hC0);
        #10000;
        i_host.shift(8'h00, 8, rd_v);
        check("pixel second", rd_v, 8'h81);
        i_host.desel(4000);
        #4000;
        at_edge();
        dev_rst = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        dev_rst = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        check("nav after reset pin", nav, 1'b1);
        i_host.wr(7'h20, 8'h44);
        i_host.wr(7'h23, 8'h07);
        i_host.wr(7'h24, 8'h88);
        check("cfg kept", cfg, 8'h3C);
        #10000;
        i_host.wr(7'h14, 8'h18);
        // Download with the drain stalled until the buffer is full
        at_edge();
        fw_ready = 1'b0;
        i_host.sel();
        i_host.shift(8'hE0, 8, rd_v);
        for (int i = 0; i < 16; i++) begin
            i_host.shift(8'hA0 + i[7:0], 8, rd_v);
            #10000;
        end
        check("load on", fw_on, 1'b1);
        check("stalled", 16'(fw_q.size()), 16'h0000);
        at_edge();
        fw_ready = 1'b1;
        for (int k = 0; k < 64 && fw_q.size() < 16; k++)
            @(posedge clk);
        check("image count", 16'(fw_q.size()), 16'h0010);
        foreach (fw_q[i])
            check("image byte", fw_q[i], 8'hA0 + i[7:0]);
        i_host.desel(4000);
        at_edge();
        pd_n = 1'b0;
        i_host.sel();
        repeat (20) @(posedge clk);
        #1;
        check("oe_n power down", oe_n, 1'b1);
        i_host.desel(0);
        at_edge();
        pd_n = 1'b1;
        tally_and_finish();
    end
endmodule // testbench
